// *** tlsw_pkg.sv ***
// Package of word offsets, field positions and codes for the loop status word bank.
package tlsw_pkg;
  localparam int          WORD_W        = 16;
  localparam logic [3:0]  OFS_PV1       = 4'h3;
  localparam logic [3:0]  OFS_PV2       = 4'h4;
  localparam logic [3:0]  OFS_SP1       = 4'h5;
  localparam logic [3:0]  OFS_SP2       = 4'h6;
  localparam logic [3:0]  OFS_DPF       = 4'h7;
  localparam logic [3:0]  OFS_FLG1      = 4'h8;
  localparam int          DP1_LSB       = 12;
  localparam int          DP2_LSB       = 8;
  localparam int          ERR1_LSB      = 4;
  localparam int          ERR2_LSB      = 0;
  localparam int          FB_SAVE_DONE  = 15;
  localparam int          FB_SENSOR     = 14;
  localparam int          FB_CT_OVER    = 13;
  localparam int          FB_FATAL      = 12;
  localparam int          FB_STANDBY    = 11;
  localparam int          FB_PID_NEW    = 10;
  localparam int          FB_SET_ERR    = 9;
  localparam int          FB_STOP       = 8;
  localparam int          FB_CTRL_OUT   = 4;
  localparam int          FB_AT_ACTIVE  = 3;
  localparam int          FB_HB         = 2;
  localparam int          FB_ALARM1     = 1;
  localparam int          FB_ALARM2     = 0;
  localparam logic [15:0] SENSOR_FAULT  = 16'hcccc;
  localparam logic [3:0]  NEG_DIGIT     = 4'hf;
  localparam logic [15:0] CT_LIMIT_DA   = 16'h0226;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [3:0]  NIB_ZERO      = 4'h0;
endpackage : tlsw_pkg

// *** tlsw_encode.sv ***
// Value encoder that formats a signed reading as BCD or binary.
`timescale 1ns/1ns
module tlsw_encode (
  input  wire logic signed [15:0] value,
  input  wire logic               bcd_sel,
  output logic             [15:0] word
);
  logic [15:0] mag;
  logic [15:0] rem;
  logic [3:0]  d0;
  logic [3:0]  d1;
  logic [3:0]  d2;
  logic [3:0]  d3;

  always_comb begin
    mag = value[15] ? 16'(-value) : 16'(value);
    d0  = 4'(mag % 16'd10);
    rem = mag / 16'd10;
    d1  = 4'(rem % 16'd10);
    rem = rem / 16'd10;
    d2  = 4'(rem % 16'd10);
    rem = rem / 16'd10;
    d3  = 4'(rem % 16'd10);
    if (!bcd_sel) begin
      word = value;
    end else if (value[15]) begin
      word = {tlsw_pkg::NEG_DIGIT, d2, d1, d0}; // R2
    end else begin
      word = {d3, d2, d1, d0}; // R1
    end
  end
endmodule : tlsw_encode

// *** tlsw_status_bank.sv ***
// Status word bank of a two-loop temperature control unit, read at each host refresh.
//
// Overview of operation
// (R1) Each loop's measured value sits in its own word, BCD or binary.
// (R2) Negative BCD words carry digit F in the top nibble.
// (R3) Out-of-range input forces the measured word to CCCC; on loop 1 it also sets sensor fault.
// (R4) Active set points of both loops are echoed, same encoding.
// (R5) Decimal code loop 1 in bits 12-15, loop 2 in bits 8-11.
// (R6) Faulty setting index loop 1 in bits 4-7, loop 2 in bits 0-3.
// (R7) Host asserts loop 1 save request to copy parameters to nonvolatile store.
// (R8) Save-done flag sets on copy finish, clears on request, clear after reset.
// (R9) Sensor error flag sets on missing, broken or out-of-range sensor.
// (R10) Coil current over flag sets when heater current exceeds 55.0 A.
// (R11) Fatal flag sets on cold-junction failure or host watchdog failure.
// (R12) Standby flag stays set until the first refresh after reset.
// (R13) New tuning constants flag sets on update, clears when host sends them.
// (R14) Setting error flag sets when any host-held setting is invalid.
// (R15) Stop flag clear while regulating, set while halted.
// (R16) Flag bits 5 to 7 read zero.
// (R17) Control output flag follows the loop control output.
// (R18) Autotune active flag set exactly while autotuning runs.
// (R19) Heater break flag sets when current reaches the failure threshold.
// (R20) Alarm flags are set while temperature lies within the alarm range.
// (R21) Host starts autotune; start is ignored while abort is asserted.
// (R22) Host deasserts halt to regulate, asserts it to halt.
// (R23) All words update together at one sampling instant.
`timescale 1ns/1ns
module tlsw_status_bank (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        CLK_EN,
  input  wire logic        REFRESH,
  input  wire logic [3:0]  RD_WORD,
  output logic      [15:0] RD_DATA,
  output logic      [15:0] MEASURED_VALUE_LOOP1,
  output logic      [15:0] MEASURED_VALUE_LOOP2,
  output logic      [15:0] ACTIVE_TARGET_LOOP1,
  output logic      [15:0] ACTIVE_TARGET_LOOP2,
  output logic      [15:0] DECIMAL_AND_FAULT_INDEX,
  output logic      [15:0] LOOP1_CONDITION_FLAGS,
  input  wire logic        BCD_SEL,
  input  wire logic [15:0] PV1,
  input  wire logic [15:0] PV2,
  input  wire logic [15:0] SP1,
  input  wire logic [15:0] SP2,
  input  wire logic        RANGE_FAULT1,
  input  wire logic        RANGE_FAULT2,
  input  wire logic        SENSOR_MISSING1,
  input  wire logic        SENSOR_BROKEN1,
  input  wire logic [3:0]  DP_CODE1,
  input  wire logic [3:0]  DP_CODE2,
  input  wire logic [3:0]  ERR_INDEX1,
  input  wire logic [3:0]  ERR_INDEX2,
  input  wire logic        SAVE_REQ1,
  input  wire logic        SAVE_DONE1,
  input  wire logic [15:0] HEATER_CURRENT1,
  input  wire logic [15:0] HB_THRESHOLD1,
  input  wire logic        CJC_FAIL,
  input  wire logic        CPU_WATCHDOG_FAIL,
  input  wire logic        TUNE_UPDATED1,
  input  wire logic        TUNE_SENT1,
  input  wire logic        SETTING_INVALID1,
  input  wire logic        HALT1,
  input  wire logic        CTRL_OUT1,
  input  wire logic        AUTOTUNE_BEGIN_BIT1,
  input  wire logic        AUTOTUNE_ABORT_BIT1,
  input  wire logic        AUTOTUNE_DONE1,
  input  wire logic        ALARM_IN_RANGE1,
  input  wire logic        ALARM_IN_RANGE2
);
  logic [15:0] pv1_enc;
  logic [15:0] pv2_enc;
  logic [15:0] sp1_enc;
  logic [15:0] sp2_enc;
  logic [15:0] next_flags;
  logic        save_done;
  logic        tune_new;
  logic        standby;
  logic        tuning;
  logic        save_req_q;

  // The flag word leaves reset showing standby, so the host sees the unit waiting for its first refresh.
  localparam logic [15:0] FLAGS_AT_RESET = tlsw_pkg::WORD_ZERO | (16'h0001 << tlsw_pkg::FB_STANDBY);

  ////////////////////////////////////////////////////////////////////////////
  // Encoders for measured values and set points.

  tlsw_encode u_pv1 (.value(PV1), .bcd_sel(BCD_SEL), .word(pv1_enc)); // R1
  tlsw_encode u_pv2 (.value(PV2), .bcd_sel(BCD_SEL), .word(pv2_enc)); // R1
  tlsw_encode u_sp1 (.value(SP1), .bcd_sel(BCD_SEL), .word(sp1_enc)); // R4
  tlsw_encode u_sp2 (.value(SP2), .bcd_sel(BCD_SEL), .word(sp2_enc)); // R4

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags.

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      save_done  <= 1'b0; // R8
      save_req_q <= 1'b0;
    end else if (CLK_EN) begin
      save_req_q <= SAVE_REQ1;
      if (SAVE_DONE1) begin
        save_done <= 1'b1; // R8
      end else if (SAVE_REQ1 && !save_req_q) begin
        save_done <= 1'b0; // R8
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      tune_new <= 1'b0;
    end else if (CLK_EN) begin
      if (TUNE_UPDATED1) begin
        tune_new <= 1'b1; // R13
      end else if (TUNE_SENT1) begin
        tune_new <= 1'b0; // R13
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      standby <= 1'b1; // R12
    end else if (CLK_EN && REFRESH) begin
      standby <= 1'b0; // R12
    end
  end

  // Autotune runs from an accepted start until done, aborted or halted.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      tuning <= 1'b0;
    end else if (CLK_EN) begin
      if (AUTOTUNE_ABORT_BIT1 || AUTOTUNE_DONE1 || HALT1) begin
        tuning <= 1'b0; // R21
      end else if (AUTOTUNE_BEGIN_BIT1) begin
        tuning <= 1'b1; // R18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag word assembly.

  always_comb begin
    next_flags                           = tlsw_pkg::WORD_ZERO; // R16
    next_flags[tlsw_pkg::FB_SAVE_DONE]   = save_done; // R8
    next_flags[tlsw_pkg::FB_SENSOR]      = RANGE_FAULT1 | SENSOR_MISSING1 | SENSOR_BROKEN1; // R9
    next_flags[tlsw_pkg::FB_CT_OVER]     = HEATER_CURRENT1 > tlsw_pkg::CT_LIMIT_DA; // R10
    next_flags[tlsw_pkg::FB_FATAL]       = CJC_FAIL | CPU_WATCHDOG_FAIL; // R11
    next_flags[tlsw_pkg::FB_STANDBY]     = standby & ~REFRESH; // R12
    next_flags[tlsw_pkg::FB_PID_NEW]     = tune_new; // R13
    next_flags[tlsw_pkg::FB_SET_ERR]     = SETTING_INVALID1; // R14
    next_flags[tlsw_pkg::FB_STOP]        = HALT1; // R15 R22
    next_flags[tlsw_pkg::FB_CTRL_OUT]    = CTRL_OUT1; // R17
    next_flags[tlsw_pkg::FB_AT_ACTIVE]   = tuning; // R18
    next_flags[tlsw_pkg::FB_HB]          = HEATER_CURRENT1 >= HB_THRESHOLD1; // R19
    next_flags[tlsw_pkg::FB_ALARM1]      = ALARM_IN_RANGE1; // R20
    next_flags[tlsw_pkg::FB_ALARM2]      = ALARM_IN_RANGE2; // R20
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot of all words, taken together on each refresh.

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      MEASURED_VALUE_LOOP1    <= tlsw_pkg::WORD_ZERO;
      MEASURED_VALUE_LOOP2    <= tlsw_pkg::WORD_ZERO;
      ACTIVE_TARGET_LOOP1     <= tlsw_pkg::WORD_ZERO;
      ACTIVE_TARGET_LOOP2     <= tlsw_pkg::WORD_ZERO;
      DECIMAL_AND_FAULT_INDEX <= tlsw_pkg::WORD_ZERO;
      LOOP1_CONDITION_FLAGS   <= FLAGS_AT_RESET; // R12
    end else if (CLK_EN && REFRESH) begin
      MEASURED_VALUE_LOOP1    <= RANGE_FAULT1 ? tlsw_pkg::SENSOR_FAULT : pv1_enc; // R3 R23
      MEASURED_VALUE_LOOP2    <= RANGE_FAULT2 ? tlsw_pkg::SENSOR_FAULT : pv2_enc; // R3
      ACTIVE_TARGET_LOOP1     <= sp1_enc; // R4
      ACTIVE_TARGET_LOOP2     <= sp2_enc; // R4
      DECIMAL_AND_FAULT_INDEX <= {DP_CODE1, DP_CODE2, ERR_INDEX1, ERR_INDEX2}; // R5 R6
      LOOP1_CONDITION_FLAGS   <= next_flags; // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word read port.

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      RD_DATA <= tlsw_pkg::WORD_ZERO;
    end else if (CLK_EN) begin
      case (RD_WORD)
        tlsw_pkg::OFS_PV1:  RD_DATA <= MEASURED_VALUE_LOOP1;
        tlsw_pkg::OFS_PV2:  RD_DATA <= MEASURED_VALUE_LOOP2;
        tlsw_pkg::OFS_SP1:  RD_DATA <= ACTIVE_TARGET_LOOP1;
        tlsw_pkg::OFS_SP2:  RD_DATA <= ACTIVE_TARGET_LOOP2;
        tlsw_pkg::OFS_DPF:  RD_DATA <= DECIMAL_AND_FAULT_INDEX;
        tlsw_pkg::OFS_FLG1: RD_DATA <= LOOP1_CONDITION_FLAGS;
        default:            RD_DATA <= tlsw_pkg::WORD_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_fault_pattern: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R3
    CLK_EN && REFRESH && RANGE_FAULT1 |=> MEASURED_VALUE_LOOP1 == tlsw_pkg::SENSOR_FAULT)
    else $error("Fault pattern missing on loop 1 word.");
  a_sensor_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R9
    CLK_EN && REFRESH && SENSOR_BROKEN1 |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_SENSOR])
    else $error("Sensor flag not set.");
  a_save_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R8
    CLK_EN && SAVE_REQ1 && !save_req_q && !SAVE_DONE1 |=> !save_done)
    else $error("Save flag not cleared by request.");
  a_save_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R8
    CLK_EN && SAVE_DONE1 |=> save_done)
    else $error("Save flag not set on completion.");
  a_standby_drop: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R12
    CLK_EN && REFRESH |=> !standby ##1 !standby)
    else $error("Standby flag did not clear.");
  a_tune_new: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R13
    CLK_EN && TUNE_UPDATED1 |=> tune_new)
    else $error("Tuning flag not set.");
  a_abort_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R21
    CLK_EN && AUTOTUNE_ABORT_BIT1 |=> !tuning)
    else $error("Autotune started under abort.");
  a_ct_over: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R10
    CLK_EN && REFRESH && HEATER_CURRENT1 > tlsw_pkg::CT_LIMIT_DA |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_CT_OVER])
    else $error("Current over flag missing.");
  a_zero_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R16
    LOOP1_CONDITION_FLAGS[7:5] == 3'h0)
    else $error("Reserved flag bits not zero.");
  a_packed_word: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R5
    CLK_EN && REFRESH |=> DECIMAL_AND_FAULT_INDEX[15:12] == $past(DP_CODE1))
    else $error("Decimal code misplaced.");
  // Flag word properties other than a_standby_shown, a_zero_bits, a_words_hold and a_read_flags compare each bit with the level sampled at the refresh edge.
  a_standby_shown: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R12
    LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_STANDBY] == standby)
    else $error("Standby flag does not show the waiting state.");
  a_neg_target: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R2
    CLK_EN && REFRESH && BCD_SEL && SP1[15] |=> ACTIVE_TARGET_LOOP1[tlsw_pkg::WORD_W-1 -: 4] == tlsw_pkg::NEG_DIGIT)
    else $error("Negative set point lacks the sign digit.");
  a_neg_measured: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R2
    CLK_EN && REFRESH && BCD_SEL && PV1[15] && !RANGE_FAULT1 |=>
      MEASURED_VALUE_LOOP1[tlsw_pkg::WORD_W-1 -: 4] == tlsw_pkg::NEG_DIGIT)
    else $error("Negative measured value lacks the sign digit.");
  a_binary_target: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R4
    CLK_EN && REFRESH && !BCD_SEL |=> ACTIVE_TARGET_LOOP2 == $past(SP2))
    else $error("Binary set point not echoed.");
  a_binary_measured: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R1
    CLK_EN && REFRESH && !BCD_SEL && !RANGE_FAULT2 |=> MEASURED_VALUE_LOOP2 == $past(PV2))
    else $error("Binary measured value not reported.");
  a_fault_pattern2: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R3
    CLK_EN && REFRESH && RANGE_FAULT2 |=> MEASURED_VALUE_LOOP2 == tlsw_pkg::SENSOR_FAULT)
    else $error("Fault pattern missing on loop 2 word.");
  a_decimal_loop2: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R5
    CLK_EN && REFRESH |=> DECIMAL_AND_FAULT_INDEX[tlsw_pkg::DP2_LSB +: 4] == $past(DP_CODE2))
    else $error("Loop 2 decimal code misplaced.");
  a_error_index: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R6
    CLK_EN && REFRESH |=> DECIMAL_AND_FAULT_INDEX[tlsw_pkg::ERR1_LSB +: 4] == $past(ERR_INDEX1) &&
      DECIMAL_AND_FAULT_INDEX[tlsw_pkg::ERR2_LSB +: 4] == $past(ERR_INDEX2))
    else $error("Setting error index misplaced.");
  a_sensor_missing: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R9
    CLK_EN && REFRESH && SENSOR_MISSING1 |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_SENSOR])
    else $error("Sensor flag not set for a missing sensor.");
  a_ct_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R10
    CLK_EN && REFRESH && HEATER_CURRENT1 <= tlsw_pkg::CT_LIMIT_DA |=> !LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_CT_OVER])
    else $error("Current over flag set below the limit.");
  a_fatal_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R11
    CLK_EN && REFRESH && (CJC_FAIL || CPU_WATCHDOG_FAIL) |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_FATAL])
    else $error("Fatal flag not set.");
  a_tune_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R13
    CLK_EN && TUNE_SENT1 && !TUNE_UPDATED1 |=> !tune_new)
    else $error("Tuning flag not cleared after sending.");
  a_setting_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R14
    CLK_EN && REFRESH |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_SET_ERR] == $past(SETTING_INVALID1))
    else $error("Setting error flag wrong.");
  a_stop_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R15
    CLK_EN && REFRESH |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_STOP] == $past(HALT1))
    else $error("Stop flag wrong.");
  a_ctrl_out: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R17
    CLK_EN && REFRESH |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_CTRL_OUT] == $past(CTRL_OUT1))
    else $error("Control output flag wrong.");
  a_tune_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R18
    CLK_EN && REFRESH |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_AT_ACTIVE] == $past(tuning))
    else $error("Autotune flag wrong.");
  a_heater_break: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R19
    CLK_EN && REFRESH && HEATER_CURRENT1 >= HB_THRESHOLD1 |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_HB])
    else $error("Heater break flag not set.");
  a_alarm_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R20
    CLK_EN && REFRESH |=> LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_ALARM1] == $past(ALARM_IN_RANGE1) &&
      LOOP1_CONDITION_FLAGS[tlsw_pkg::FB_ALARM2] == $past(ALARM_IN_RANGE2))
    else $error("Alarm flags wrong.");
  a_words_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R23
    !(CLK_EN && REFRESH) |=> $stable(LOOP1_CONDITION_FLAGS) && $stable(MEASURED_VALUE_LOOP1))
    else $error("Status words changed without a refresh.");
  a_read_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R23
    CLK_EN && RD_WORD == tlsw_pkg::OFS_FLG1 |=> RD_DATA == $past(LOOP1_CONDITION_FLAGS))
    else $error("Flag word read wrong.");
  a_read_unmapped: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R23
    CLK_EN && (RD_WORD < tlsw_pkg::OFS_PV1 || RD_WORD > tlsw_pkg::OFS_FLG1) |=> RD_DATA == tlsw_pkg::WORD_ZERO)
    else $error("Unmapped word read not zero.");
endmodule : tlsw_status_bank

// *** tlsw_host_model.sv ***
// Host controller model that maps its output word onto the unit's request pins.
`timescale 1ns/1ns
module tlsw_host_model (
  input  wire logic [15:0] out_word,
  input  wire logic        req,
  output logic             refresh,
  output logic             save_req1,
  output logic             halt1,
  output logic             at_abort1,
  output logic             at_begin1
);
  ////////////////////////////////////////////////////////////////////////////////
  // The refresh strobe follows the bench request in the same cycle.
  assign refresh   = req;
  assign save_req1 = out_word[15];
  assign halt1     = out_word[6];
  assign at_abort1 = out_word[3];
  assign at_begin1 = out_word[2];
endmodule : tlsw_host_model

// *** tb_temp_loop_status_words.sv ***
// Self-checking testbench of the loop status word bank, driven through a host model.
`timescale 1ns/1ns
module tb_temp_loop_status_words;
  logic        SYS_CLK, RST_B, CLK_EN, REFRESH, BCD_SEL, RANGE_FAULT1, RANGE_FAULT2, SENSOR_MISSING1;
  logic        SENSOR_BROKEN1, SAVE_REQ1, CJC_FAIL, CPU_WATCHDOG_FAIL, SETTING_INVALID1, HALT1, CTRL_OUT1;
  logic        AUTOTUNE_BEGIN_BIT1, AUTOTUNE_ABORT_BIT1, ALARM_IN_RANGE1, ALARM_IN_RANGE2, req;
  logic        e_sv, e_tn, e_at;
  logic [3:0]  RD_WORD, DP_CODE1, DP_CODE2, ERR_INDEX1, ERR_INDEX2, ev;
  logic [15:0] RD_DATA, MEASURED_VALUE_LOOP1, MEASURED_VALUE_LOOP2, ACTIVE_TARGET_LOOP1;
  logic [15:0] ACTIVE_TARGET_LOOP2, DECIMAL_AND_FAULT_INDEX, LOOP1_CONDITION_FLAGS;
  logic [15:0] PV1, PV2, SP1, SP2, HEATER_CURRENT1, HB_THRESHOLD1, host_word;
  logic [15:0] exp_w [3:8];
  wire         SAVE_DONE1, TUNE_UPDATED1, TUNE_SENT1, AUTOTUNE_DONE1;
  int          errors, n_tests, it;

  assign {AUTOTUNE_DONE1, TUNE_SENT1, TUNE_UPDATED1, SAVE_DONE1} = ev;
  tlsw_host_model host (
    .out_word  (host_word),
    .req       (req),
    .refresh   (REFRESH),
    .save_req1 (SAVE_REQ1),
    .halt1     (HALT1),
    .at_abort1 (AUTOTUNE_ABORT_BIT1),
    .at_begin1 (AUTOTUNE_BEGIN_BIT1)
  );
  tlsw_status_bank DUT (.*);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] enc(input logic [15:0] v, input logic b);
    logic [15:0] m;
    m = v[15] ? -v : v;
    if (!b) return v;
    return {v[15] ? 4'hf : 4'(m / 1000), 4'(m / 100 % 10), 4'(m / 10 % 10), 4'(m % 10)};
  endfunction : enc

  task automatic calc();
    exp_w[3] = RANGE_FAULT1 ? 16'hcccc : enc(PV1, BCD_SEL);
    exp_w[4] = RANGE_FAULT2 ? 16'hcccc : enc(PV2, BCD_SEL);
    exp_w[5] = enc(SP1, BCD_SEL);
    exp_w[6] = enc(SP2, BCD_SEL);
    exp_w[7] = {DP_CODE1, DP_CODE2, ERR_INDEX1, ERR_INDEX2};
    exp_w[8] = {e_sv, RANGE_FAULT1 | SENSOR_MISSING1 | SENSOR_BROKEN1, HEATER_CURRENT1 > 16'h0226,
                CJC_FAIL | CPU_WATCHDOG_FAIL, 1'b0, e_tn, SETTING_INVALID1, HALT1, 3'h0, CTRL_OUT1,
                e_at, HEATER_CURRENT1 >= HB_THRESHOLD1, ALARM_IN_RANGE1, ALARM_IN_RANGE2};
  endtask : calc

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // The CTRL_OUT1 input is toggled after the refresh edge so reads must come from the snapshot.
  task automatic snap();
    @(posedge SYS_CLK) req <= 1'b1;
    calc();
    @(posedge SYS_CLK) req <= 1'b0;
    CTRL_OUT1 <= ~CTRL_OUT1;
    #1;
    chk(MEASURED_VALUE_LOOP1, exp_w[3]);
    chk(MEASURED_VALUE_LOOP2, exp_w[4]);
    chk(ACTIVE_TARGET_LOOP1, exp_w[5]);
    chk(ACTIVE_TARGET_LOOP2, exp_w[6]);
    chk(DECIMAL_AND_FAULT_INDEX, exp_w[7]);
    chk(LOOP1_CONDITION_FLAGS, exp_w[8]);
    for (int i = 0; i < 16; i++) begin
      @(posedge SYS_CLK) RD_WORD <= 4'(i);
      @(posedge SYS_CLK) #1;
      chk(RD_DATA, (i inside {[3:8]}) ? exp_w[i] : 16'h0000);
    end
  endtask : snap

  task automatic pulse(input logic [3:0] m);
    @(posedge SYS_CLK) ev <= m;
    @(posedge SYS_CLK) ev <= 4'h0;
  endtask : pulse

  task automatic rnd();
    @(posedge SYS_CLK) BCD_SEL <= 1'($urandom);
    PV1 <= 16'(int'($urandom_range(1998)) - 999);
    PV2 <= 16'(int'($urandom_range(1998)) - 999);
    SP1 <= 16'(int'($urandom_range(1998)) - 999);
    SP2 <= 16'(int'($urandom_range(1998)) - 999);
    {RANGE_FAULT1, RANGE_FAULT2, SENSOR_MISSING1, SENSOR_BROKEN1, CJC_FAIL, CPU_WATCHDOG_FAIL,
     SETTING_INVALID1, CTRL_OUT1, ALARM_IN_RANGE1, ALARM_IN_RANGE2} <= 10'($urandom & $urandom);
    {DP_CODE1, DP_CODE2, ERR_INDEX1, ERR_INDEX2} <= 16'($urandom);
    HEATER_CURRENT1 <= 16'($urandom_range(32'h240, 32'h200));
    HB_THRESHOLD1 <= 16'($urandom_range(32'h240, 32'h200));
    host_word[6] <= 1'($urandom);
  endtask : rnd

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    {RST_B, errors, n_tests, e_sv, e_tn, e_at, RD_WORD, BCD_SEL, PV1, PV2, SP1, SP2, ev, req} = '0;
    {RANGE_FAULT1, RANGE_FAULT2, SENSOR_MISSING1, SENSOR_BROKEN1, DP_CODE1, DP_CODE2} = '0;
    {ERR_INDEX1, ERR_INDEX2, HEATER_CURRENT1, HB_THRESHOLD1, CJC_FAIL, CPU_WATCHDOG_FAIL} = '0;
    {SETTING_INVALID1, CTRL_OUT1, ALARM_IN_RANGE1, ALARM_IN_RANGE2, host_word} = '0;
    CLK_EN = 1'b1;
    void'($urandom(30));
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    #1;
    chk(LOOP1_CONDITION_FLAGS, 16'h0800);
    snap();
    for (it = 0; it < 24; it++) begin
      rnd();
      if (it == 0) begin
        {BCD_SEL, PV1, SP1} <= {1'b1, 16'hfc19, 16'd9999};
        {HEATER_CURRENT1, HB_THRESHOLD1} <= {16'h0226, 16'h0226};
      end
      if (it == 1) {BCD_SEL, RANGE_FAULT1, HEATER_CURRENT1} <= {1'b1, 1'b1, 16'h0227};
      snap();
    end
    $display("Random level test done");
    @(posedge SYS_CLK) host_word <= 16'h0000;
    pulse(4'h1);
    e_sv = 1'b1;
    snap();
    @(posedge SYS_CLK) host_word[15] <= 1'b1;
    e_sv = 1'b0;
    snap();
    pulse(4'h6);
    e_tn = 1'b1;
    snap();
    pulse(4'h4);
    e_tn = 1'b0;
    snap();
    $display("Save and tuning flag test done");
    @(posedge SYS_CLK) host_word <= 16'h0004;
    @(posedge SYS_CLK) host_word <= 16'h0000;
    e_at = 1'b1;
    snap();
    pulse(4'h8);
    e_at = 1'b0;
    snap();
    foreach (exp_w[k]) if (k == 3 || k == 4) begin
      @(posedge SYS_CLK) host_word <= (k == 3) ? 16'h000c : 16'h0044;
      @(posedge SYS_CLK) host_word <= 16'h0000;
      snap();
    end
    $display("Autotune test done");
    @(posedge SYS_CLK) CLK_EN <= 1'b0;
    host_word[6] <= 1'b1;
    req <= 1'b1;
    @(posedge SYS_CLK) req <= 1'b0;
    @(posedge SYS_CLK) CLK_EN <= 1'b1;
    #1;
    chk(LOOP1_CONDITION_FLAGS, exp_w[8]);
    $display("Clock enable test done");
    pulse(4'h3);
    @(posedge SYS_CLK) RST_B <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk(LOOP1_CONDITION_FLAGS, 16'h0800);
    chk(MEASURED_VALUE_LOOP1, 16'h0000);
    @(posedge SYS_CLK) RST_B <= 1'b1;
    snap();
    $display("Reset test done");
    end_of_test();
  end
endmodule : tb_temp_loop_status_words
